// >>> cgx_pkg.sv
// package for the clock generator external reference switch block
// assumes an 8-bit register port and one 200 MHz clock
package cgx_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [2:0] CGX_OFF_CTRL1  = 3'h0;
    localparam logic [2:0] CGX_OFF_CTRL2  = 3'h1;
    localparam logic [2:0] CGX_OFF_STATUS = 3'h2;
    localparam logic [2:0] CGX_OFF_CTRL3  = 3'h3;
    localparam logic [2:0] CGX_OFF_IRQ_ST = 3'h4;
    localparam logic [2:0] CGX_OFF_IRQ_MK = 3'h5;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CGX_CLKSEL_LSB  = 6;
    localparam int CGX_REFDIV_LSB  = 3;
    localparam int CGX_IREFSEL_BIT = 2;
    localparam int CGX_BUS_CLOCK_DIVIDER_LSB    = 6;
    localparam int CGX_RANGE_BIT   = 5;
    localparam int CGX_HGO_BIT     = 4;
    localparam int CGX_XTAL_BIT    = 2;
    localparam int CGX_EREN_BIT    = 1;
    localparam int CGX_SCALE_BIT   = 4;
    localparam int CGX_REFST_BIT   = 4;
    localparam int CGX_CLOCK_SOURCE_STATUS_LSB   = 2;
    localparam int CGX_OSCOK_BIT   = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CGX_RST_CTRL1 = 8'h04;
    localparam logic [7:0] CGX_RST_CTRL2 = 8'h00;
    localparam logic [7:0] CGX_RST_CTRL3 = 8'h00;
    localparam logic [7:0] CGX_RST_MASK  = 8'h00;

    // ------------------------------------------------------------
    // encodings and timing
    // ------------------------------------------------------------
    localparam logic [1:0] CGX_SRC_FLL = 2'h0;
    localparam logic [1:0] CGX_SRC_INT = 2'h1;
    localparam logic [1:0] CGX_SRC_EXT = 2'h2;
    localparam logic [1:0] CGX_SRC_PLL = 2'h3;
    localparam int CGX_CLK_MHZ        = 200;
    localparam int CGX_OSC_START_US   = 10;
    localparam int CGX_OSC_START_CYC  = CGX_OSC_START_US * CGX_CLK_MHZ;
    localparam int CGX_SWITCH_CYC     = 4;
    localparam int CGX_DIV_DEF        = 8;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic [2:0] ref_div;
        logic       int_ref;
    } cgx_ctrl_s;

    typedef enum logic [2:0] {
        CGX_OSC_OFF  = 3'b001,
        CGX_OSC_WAIT = 3'b010,
        CGX_OSC_RUN  = 3'b100
    } cgx_osc_e;

endpackage : cgx_pkg

// >>> cgx_clock_gen.sv
// clock generator mode control: registers, oscillator start, source switch
// assumes the crystal clock pin from outside, register port master
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Function
// - reset into fll engaged internal mode
// - bus divider bits 7:6, 00 divides by one
// - bit 5 selects high frequency range
// - bit 4 selects high oscillator gain
// - bit 2 selects crystal reference
// - bit 1 keeps external reference running
// - status bit 1 shows crystal initialised
// - extra scaling bit 4 in high range
// - source select 10 picks external reference
// - divider 011 with scaling divides by 256
// - internal select cleared picks external reference
// - status bit 4 zero when external
// - clock status 10 when external feeds output
module cgx_clock_gen
    import cgx_pkg::*;
#(
    parameter int OSC_START_CYC = CGX_OSC_START_CYC
)(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       osc_clk_pin_i,
    output logic            osc_enable_o,
    output logic            osc_high_gain_select_o,
    output logic            osc_high_range_o,
    output logic            ext_ref_crystal_select_o,
    output logic            ext_ref_clock_enable_o,
    output logic      [1:0] bus_clock_divider_o,
    output logic      [1:0] clock_out_select_o,
    output logic            ref_is_internal_o,
    output logic      [3:0] fll_ref_div_log2_o,
    output logic            irq_o
);

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [7:0] ctrl3_q;
    logic [7:0] irq_st_q;
    logic [7:0] irq_mk_q;
    logic [7:0] status;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;

    // ------------------------------------------------------------
    // address match, shared by every write strobe
    // ------------------------------------------------------------
    function automatic logic reg_hit(
        input logic [2:0] addr,
        input logic [2:0] idx,
        input logic       strobe
    );
        reg_hit = strobe && (addr == idx);
    endfunction : reg_hit

    // ------------------------------------------------------------
    // write strobes per register
    // ------------------------------------------------------------
    // status and unmapped indices get no strobe
    wire wr_c1 = reg_hit(addr_i, CGX_OFF_CTRL1, wr_i);
    wire wr_c2 = reg_hit(addr_i, CGX_OFF_CTRL2, wr_i);
    wire wr_c3 = reg_hit(addr_i, CGX_OFF_CTRL3, wr_i);
    wire wr_is = reg_hit(addr_i, CGX_OFF_IRQ_ST, wr_i);
    wire wr_im = reg_hit(addr_i, CGX_OFF_IRQ_MK, wr_i);

    // ------------------------------------------------------------
    // read selection
    // ------------------------------------------------------------
    always_comb
    begin
        case (addr_i)
            CGX_OFF_CTRL1:  rd_mux = ctrl1_q;
            CGX_OFF_CTRL2:  rd_mux = ctrl2_q;
            CGX_OFF_STATUS: rd_mux = status;
            CGX_OFF_CTRL3:  rd_mux = ctrl3_q;
            CGX_OFF_IRQ_ST: rd_mux = irq_st_q;
            CGX_OFF_IRQ_MK: rd_mux = irq_mk_q;
            default:        rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            ctrl1_q <= CGX_RST_CTRL1;
        else if (wr_c1)
            ctrl1_q <= wdata_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            ctrl2_q <= CGX_RST_CTRL2;
        else if (wr_c2)
            ctrl2_q <= wdata_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            ctrl3_q <= CGX_RST_CTRL3;
        else if (wr_c3)
            ctrl3_q <= wdata_i;
    end

    // ------------------------------------------------------------
    // interrupt mask register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            irq_mk_q <= CGX_RST_MASK;
        else if (wr_im)
            irq_mk_q <= wdata_i;
    end

    // ------------------------------------------------------------
    // read data, zero outside the answer cycle
    // ------------------------------------------------------------
    // status writes fall through: no store
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            rdata_q <= 8'h00;
        else
            rdata_q <= rd_i ? rd_mux : 8'h00;
    end
    assign rdata_o = rdata_q;

    // ------------------------------------------------------------
    // field views
    // ------------------------------------------------------------
    cgx_ctrl_s c1;
    assign c1 = {ctrl1_q[CGX_CLKSEL_LSB +: 2],
                 ctrl1_q[CGX_REFDIV_LSB +: 3],
                 ctrl1_q[CGX_IREFSEL_BIT]};
    wire range_hi = ctrl2_q[CGX_RANGE_BIT];
    wire xtal_sel = ctrl2_q[CGX_XTAL_BIT];
    wire er_en    = ctrl2_q[CGX_EREN_BIT];
    wire scale    = ctrl3_q[CGX_SCALE_BIT];

    // ------------------------------------------------------------
    // oscillator and bus divider controls
    // ------------------------------------------------------------
    assign bus_clock_divider_o      = ctrl2_q[CGX_BUS_CLOCK_DIVIDER_LSB +: 2];
    assign osc_high_range_o         = range_hi;
    assign osc_high_gain_select_o   = ctrl2_q[CGX_HGO_BIT];
    assign ext_ref_crystal_select_o = xtal_sel;
    assign ext_ref_clock_enable_o   = er_en;

    // ------------------------------------------------------------
    // fll reference divide as power of two
    // ------------------------------------------------------------
    // 2^(reference_divider), or 2^(reference_divider+5) with extra scaling
    wire use_scale = range_hi && scale;
    assign fll_ref_div_log2_o = use_scale
        ? ({1'b0, c1.ref_div} + 4'h5)
        : {1'b0, c1.ref_div};

    // ------------------------------------------------------------
    // oscillator request
    // ------------------------------------------------------------
    // external reference needed when selected by any path
    wire ext_needed = er_en || !c1.int_ref
        || (c1.clk_sel == CGX_SRC_EXT);
    assign osc_enable_o = ext_needed;

    // ------------------------------------------------------------
    // oscillator pin synchroniser and activity detect
    // ------------------------------------------------------------
    logic [2:0] pin_q;
    logic       pin_lvl_q;
    wire        pin_edge = (pin_q[2] == pin_q[1]) && (pin_q[1] != pin_lvl_q);
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            pin_q <= 3'h0;
        else
            pin_q <= {pin_q[1:0], osc_clk_pin_i};
    end

    // ------------------------------------------------------------
    // settled pin level, taken when stages two and three agree
    // ------------------------------------------------------------
    wire pin_agree = (pin_q[2] == pin_q[1]);

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            pin_lvl_q <= 1'b0;
        else if (pin_agree)
            pin_lvl_q <= pin_q[1];
    end

    // ------------------------------------------------------------
    // oscillator start-up state machine
    // ------------------------------------------------------------
    cgx_osc_e   osc_q;
    cgx_osc_e   osc_d;
    logic [31:0] cnt_q;
    logic       seen_q;
    wire        cnt_done = (cnt_q >= 32'(OSC_START_CYC - 1));

    always_comb
    begin
        osc_d = osc_q;
        case (osc_q)
            CGX_OSC_OFF:
                if (ext_needed)
                    osc_d = CGX_OSC_WAIT;
            CGX_OSC_WAIT:
                if (!ext_needed)
                    osc_d = CGX_OSC_OFF;
                else if (cnt_done && (seen_q || !xtal_sel))
                    osc_d = CGX_OSC_RUN;
            CGX_OSC_RUN:
                if (!ext_needed)
                    osc_d = CGX_OSC_OFF;
            default:
                osc_d = CGX_OSC_OFF;
        endcase
    end

    // ------------------------------------------------------------
    // oscillator state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            osc_q <= CGX_OSC_OFF;
        else
            osc_q <= osc_d;
    end

    // ------------------------------------------------------------
    // start-up counter and pin activity latch
    // ------------------------------------------------------------
    // both restart whenever the wait state is left
    wire osc_waiting = (osc_q == CGX_OSC_WAIT);

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || !osc_waiting)
            cnt_q <= 32'h0;
        else if (!cnt_done)
            cnt_q <= cnt_q + 32'h1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || !osc_waiting)
            seen_q <= 1'b0;
        else if (pin_edge)
            seen_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // oscillator ready flag
    // ------------------------------------------------------------
    wire osc_ok = (osc_q == CGX_OSC_RUN) && xtal_sel;

    // ------------------------------------------------------------
    // reference and output source switch
    // ------------------------------------------------------------
    logic       ref_int_q;
    logic [1:0] clock_source_status_q;
    logic [2:0] sw_cnt_q;
    wire ext_ready = (osc_q == CGX_OSC_RUN);
    wire ref_tgt   = c1.int_ref || !ext_ready;
    wire [1:0] clk_tgt = (c1.clk_sel == CGX_SRC_EXT && !ext_ready)
        ? clock_source_status_q : c1.clk_sel;
    wire sw_pend = (ref_tgt != ref_int_q) || (clk_tgt != clock_source_status_q);

    // ------------------------------------------------------------
    // switch hold counter
    // ------------------------------------------------------------
    // a mismatch must stand for the full count before status moves
    wire sw_fire = sw_pend && (sw_cnt_q == 3'(CGX_SWITCH_CYC - 1));

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || !sw_pend || sw_fire)
            sw_cnt_q <= 3'h0;
        else
            sw_cnt_q <= sw_cnt_q + 3'h1;
    end

    // ------------------------------------------------------------
    // reference and clock source status
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            ref_int_q <= 1'b1;
        else if (sw_fire)
            ref_int_q <= ref_tgt;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            clock_source_status_q <= CGX_SRC_FLL;
        else if (sw_fire)
            clock_source_status_q <= clk_tgt;
    end
    assign clock_out_select_o = clock_source_status_q;
    assign ref_is_internal_o  = ref_int_q;

    // ------------------------------------------------------------
    // status register assembly
    // ------------------------------------------------------------
    function automatic logic [7:0] pack_status(
        input logic       ref_int,
        input logic [1:0] clk_src,
        input logic       osc_done
    );
        logic [7:0] s;
        s = 8'h00;
        s[CGX_REFST_BIT] = ref_int;
        s[CGX_CLOCK_SOURCE_STATUS_LSB +: 2] = clk_src;
        s[CGX_OSCOK_BIT] = osc_done;
        pack_status = s;
    endfunction : pack_status

    assign status = pack_status(ref_int_q, clock_source_status_q, osc_ok);

    // ------------------------------------------------------------
    // events: osc ready, ref change, clock change
    // ------------------------------------------------------------
    // status of the previous cycle, edges against it raise events
    logic [7:0] prev_q;
    wire        ev_osc = osc_ok && !prev_q[CGX_OSCOK_BIT];
    wire        ev_ref = ref_int_q != prev_q[CGX_REFST_BIT];
    wire        ev_clk = clock_source_status_q != prev_q[CGX_CLOCK_SOURCE_STATUS_LSB +: 2];
    wire [7:0]  ev     = {5'h0, ev_clk, ev_ref, ev_osc};
    wire [7:0]  clr    = wr_is ? wdata_i : 8'h00;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            prev_q <= pack_status(1'b1, CGX_SRC_FLL, 1'b0);
        else
            prev_q <= status;
    end

    // ------------------------------------------------------------
    // sticky interrupt status, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            irq_st_q <= 8'h00;
        else
            irq_st_q <= (irq_st_q & ~clr) | ev;
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    assign irq_o = |(irq_st_q & irq_mk_q);

endmodule : cgx_clock_gen

// >>> cgx_checker.sv
// checker: port-level assertions for the clock generator block
// assumes only the top module ports; bound below the module
`timescale 1ns/1ps
module cgx_checker
    import cgx_pkg::*;
#(
    parameter int OSC_START_CYC = CGX_OSC_START_CYC
)(
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       osc_enable_o,
    input wire logic       osc_high_gain_select_o,
    input wire logic       osc_high_range_o,
    input wire logic       ext_ref_crystal_select_o,
    input wire logic       ext_ref_clock_enable_o,
    input wire logic [1:0] bus_clock_divider_o,
    input wire logic [1:0] clock_out_select_o,
    input wire logic       ref_is_internal_o,
    input wire logic       irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    reset_state_a: assert property (disable iff (1'b0)
        rst_i |=> ref_is_internal_o && clock_out_select_o == CGX_SRC_FLL)
        else $error("state after reset is not internal fll");
    ctrl2_upper_a: assert property (
        wr_i && addr_i == CGX_OFF_CTRL2 |=> {bus_clock_divider_o,
        osc_high_range_o, osc_high_gain_select_o} == $past(wdata_i[7:4]))
        else $error("divider, range or gain differs from write");
    ctrl2_lower_a: assert property (
        wr_i && addr_i == CGX_OFF_CTRL2 |=> {ext_ref_crystal_select_o,
        ext_ref_clock_enable_o} == $past(wdata_i[2:1]))
        else $error("crystal select or enable differs from write");
    int_ref_back_a: assert property (
        wr_i && addr_i == CGX_OFF_CTRL1 && wdata_i[CGX_IREFSEL_BIT]
        |-> ##[1:8] ref_is_internal_o)
        else $error("reference did not return to internal");
    ext_ref_osc_a: assert property (
        $fell(ref_is_internal_o) |-> osc_enable_o)
        else $error("external reference taken with oscillator off");
    ext_src_osc_a: assert property (
        $changed(clock_out_select_o) && clock_out_select_o == CGX_SRC_EXT
        |-> $past(osc_enable_o))
        else $error("external source taken with oscillator off");
    status_read_a: assert property (
        rd_i && addr_i == CGX_OFF_STATUS |=> rdata_o[4:2] ==
        {$past(ref_is_internal_o), $past(clock_out_select_o)})
        else $error("status read differs from source outputs");
    rdata_idle_a: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    mask_quiet_a: assert property (
        wr_i && addr_i == CGX_OFF_IRQ_MK && wdata_i == 8'h00 |=> !irq_o)
        else $error("interrupt high with all events masked");
endmodule : cgx_checker

bind cgx_clock_gen cgx_checker #(.OSC_START_CYC(OSC_START_CYC)) u_chk (
    .ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .osc_enable_o, .osc_high_gain_select_o, .osc_high_range_o,
    .ext_ref_crystal_select_o, .ext_ref_clock_enable_o,
    .bus_clock_divider_o, .clock_out_select_o, .ref_is_internal_o, .irq_o
);

// >>> cgx_xtal_model.sv
// external crystal oscillator model, 8 mhz or half that when slow
// assumes the enable output of the clock generator drives it
`timescale 1ns/1ps
module cgx_xtal_model (
    input  wire logic enable_i,
    input  wire logic slow_i,
    output logic      clk_o
);
    initial clk_o = 1'b0;
    // runs only while enabled, stands low otherwise
    always
    begin
        if (enable_i)
            #(slow_i ? 125.0 : 62.5) clk_o = ~clk_o;
        else
        begin
            clk_o = 1'b0;
            @(enable_i);
        end
    end
endmodule : cgx_xtal_model

// >>> tb_top.sv
// testbench: register sequences through the mode switch to external
// assumes the crystal model and a shortened oscillator start count
`timescale 1ns/1ps
module tb_top
    import cgx_pkg::*;
;
    logic       ref_clk_i = 1'b0;
    logic       rst_i;
    logic [2:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic       slow;
    logic       osc_clk_pin_i;
    logic [7:0] rdata_o;
    logic       osc_enable_o;
    logic       osc_high_gain_select_o;
    logic       osc_high_range_o;
    logic       ext_ref_crystal_select_o;
    logic       ext_ref_clock_enable_o;
    logic [1:0] bus_clock_divider_o;
    logic [1:0] clock_out_select_o;
    logic       ref_is_internal_o;
    logic [3:0] fll_ref_div_log2_o;
    logic       irq_o;
    logic [7:0] r;
    logic [7:0] c2_view;
    int         err_count = 0;
    int         checks = 0;
    logic [7:0] rst_tab [8] = '{8'h04, 8'h00, 8'h10, 8'h00,
                                8'h00, 8'h00, 8'h00, 8'h00};

    assign c2_view = {bus_clock_divider_o, osc_high_range_o,
        osc_high_gain_select_o, 1'b0, ext_ref_crystal_select_o,
        ext_ref_clock_enable_o, 1'b0};

    always #2.5 ref_clk_i = ~ref_clk_i;

    cgx_clock_gen #(.OSC_START_CYC(8)) DUT (
        .ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .osc_clk_pin_i, .osc_enable_o, .osc_high_gain_select_o,
        .osc_high_range_o, .ext_ref_crystal_select_o,
        .ext_ref_clock_enable_o, .bus_clock_divider_o,
        .clock_out_select_o, .ref_is_internal_o, .fll_ref_div_log2_o,
        .irq_o
    );

    cgx_xtal_model XTAL (
        .enable_i (osc_enable_o),
        .slow_i   (slow),
        .clk_o    (osc_clk_pin_i)
    );

    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1;
        v = rdata_o;
    endtask : rd

    task poll(input logic [7:0] m, input logic [7:0] v);
        int n;
        n = 0;
        r = ~v;
        while (((r & m) !== v) && n < 200)
        begin
            rd(CGX_OFF_STATUS, r);
            n++;
        end
        chk(r & m, v);
    endtask : poll

    task stop_test;
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    initial
    begin
        rst_i   = 1'b1;
        addr_i  = 3'h0;
        wdata_i = 8'h00;
        wr_i    = 1'b0;
        rd_i    = 1'b0;
        slow    = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rd(i[2:0], r);
            chk(r, rst_tab[i]);
        end
        wr(CGX_OFF_STATUS, 8'hff);
        rd(CGX_OFF_STATUS, r);
        chk(r, 8'h10);
        wr(CGX_OFF_IRQ_MK, 8'h07);
        wr(CGX_OFF_CTRL2, 8'h36);
        chk(c2_view, 8'h36);
        poll(8'h02, 8'h02);
        chk({7'h0, irq_o}, 8'h01);
        wr(CGX_OFF_IRQ_ST, 8'h01);
        rd(CGX_OFF_IRQ_ST, r);
        chk(r, 8'h00);
        wr(CGX_OFF_CTRL3, 8'h10);
        wr(CGX_OFF_CTRL1, 8'h98);
        poll(8'h10, 8'h00);
        poll(8'h0c, 8'h08);
        chk({6'h0, clock_out_select_o}, {6'h0, CGX_SRC_EXT});
        chk({7'h0, ref_is_internal_o}, 8'h00);
        chk({4'h0, fll_ref_div_log2_o}, 8'h08);
        wr(CGX_OFF_CTRL1, 8'h98);
        poll(8'h1c, 8'h08);
        rd(CGX_OFF_IRQ_ST, r);
        chk(r, 8'h06);
        wr(CGX_OFF_IRQ_ST, 8'h06);
        chk({7'h0, irq_o}, 8'h00);
        wr(CGX_OFF_CTRL3, 8'h00);
        chk({4'h0, fll_ref_div_log2_o}, 8'h03);
        wr(CGX_OFF_IRQ_MK, 8'h00);
        wr(CGX_OFF_CTRL1, 8'h04);
        poll(8'h1e, 8'h12);
        rd(CGX_OFF_IRQ_ST, r);
        chk(r, 8'h06);
        chk({7'h0, irq_o}, 8'h00);
        wr(CGX_OFF_CTRL2, 8'h00);
        chk({7'h0, osc_enable_o}, 8'h00);
        poll(8'h02, 8'h00);
        slow <= 1'b1;
        wr(CGX_OFF_CTRL2, 8'h36);
        poll(8'h02, 8'h02);
        wr(CGX_OFF_CTRL2, 8'hf6);
        chk(c2_view, 8'hf6);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(CGX_OFF_STATUS, r);
        chk(r, 8'h10);
        rd(CGX_OFF_CTRL2, r);
        chk(r, 8'h00);
        stop_test;
    end

    initial
    begin
        #60000;
        err_count++;
        stop_test;
    end
endmodule : tb_top
